//--- rtl/bank_legality_pkg.sv
// Package for the four-bank command legality block.
// Assumes one 50 MHz clock; all times converted to cycles here.
package bank_legality_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int PRECHARGE_TIME_NS = 15;
  localparam int ACTIVATE_TO_COLUMN_TIME_NS = 15;
  localparam int WRITE_RECOVERY_TIME_NS = 15;
  localparam int WRITE_TO_READ_TIME_NS = 10;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 75;
  // Least times round up, never below one cycle
  localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACT_TO_COL_CYC = (ACTIVATE_TO_COLUMN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_TO_READ_CYC = (WRITE_TO_READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELF_REFRESH_EXIT_CYC = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Command codes {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [3:0] CODE_ACTIVATE  = 4'h3;
  localparam logic [3:0] CODE_READ      = 4'h5;
  localparam logic [3:0] CODE_WRITE     = 4'h4;
  localparam logic [3:0] CODE_PRECHARGE = 4'h2;
  localparam logic [3:0] CODE_REFRESH   = 4'h1;
  localparam logic [3:0] CODE_LOAD_MODE = 4'h0;
  localparam logic [3:0] CODE_TERMINATE = 4'h6;
  localparam logic [3:0] CODE_NOP       = 4'h7;

  typedef enum logic [2:0] {
    CMD_NONE      = 3'b000,
    CMD_ACTIVATE  = 3'b001,
    CMD_READ      = 3'b010,
    CMD_WRITE     = 3'b011,
    CMD_PRECHARGE = 3'b100,
    CMD_ALL_BANK  = 3'b101,
    CMD_TERMINATE = 3'b110
  } cmd_t;

  typedef enum logic [2:0] {
    BANK_IDLE        = 3'b000,
    BANK_ACTIVATING  = 3'b001,
    BANK_ACTIVE      = 3'b010,
    BANK_READ        = 3'b011,
    BANK_WRITE       = 3'b100,
    BANK_AP_ACCESS   = 3'b101,
    BANK_PRECHARGING = 3'b110
  } bank_state_t;

  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE  = 3'h1;
endpackage

//--- rtl/bank_tracker.sv
// One bank's state and timing counters.
// Assumes commands arrive already decoded and qualified by the parent.
`timescale 1ns/1ns
module bank_tracker
  import bank_legality_pkg::*;
#(
  parameter int CNT_W = 5
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             hit,
  input  wire cmd_t             cmd,
  input  wire logic             auto_pre,
  input  wire logic [CNT_W-1:0] access_len,
  input  wire logic [CNT_W-1:0] burst_len,
  input  wire logic             terminate,
  output bank_state_t           state,
  output logic [CNT_W-1:0]      count
);

  bank_state_t      next_state;
  logic [CNT_W-1:0] next_count;
  logic             ap_write;
  logic             next_ap_write;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_state    = state;
    next_count    = (count != '0) ? count - 1'b1 : count;
    next_ap_write = ap_write;
    case (state)
      BANK_IDLE:
      begin
        if (hit && cmd == CMD_ACTIVATE)
        begin
          next_state = BANK_ACTIVATING;
          next_count = CNT_W'(ACT_TO_COL_CYC);
        end
      end
      BANK_ACTIVATING:
        if (count <= CNT_W'(CNT_ONE))
          next_state = BANK_ACTIVE;
      BANK_ACTIVE, BANK_READ, BANK_WRITE:
      begin
        // burst state until done or cut
        if (state != BANK_ACTIVE && (count <= CNT_W'(CNT_ONE) || terminate))
          next_state = BANK_ACTIVE;
        if (hit && (cmd == CMD_READ || cmd == CMD_WRITE))
        begin
          next_state = auto_pre ? BANK_AP_ACCESS : (cmd == CMD_READ ? BANK_READ : BANK_WRITE);
          next_count = auto_pre ? access_len : burst_len;
        end
        else if (hit && cmd == CMD_PRECHARGE)
        begin
          next_state = BANK_PRECHARGING;
          next_count = CNT_W'(PRECHARGE_CYC);
        end
      end
      BANK_AP_ACCESS:
        if (count <= CNT_W'(CNT_ONE))
        begin
          next_state = BANK_PRECHARGING;
          next_count = CNT_W'(PRECHARGE_CYC);
        end
      // back to idle after precharge time
      BANK_PRECHARGING:
        if (count <= CNT_W'(CNT_ONE))
          next_state = BANK_IDLE;
      default:
        next_state = BANK_IDLE;
    endcase
    if (hit)
      next_ap_write = (cmd == CMD_WRITE);
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state    <= BANK_IDLE;
      count    <= '0;
      ap_write <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      count    <= next_count;
      ap_write <= next_ap_write;
    end
  end

  a_pre_to_idle: assert property (@(posedge clk) disable iff (!rst_n)
    state == BANK_PRECHARGING && count == CNT_W'(CNT_ONE) |=> state == BANK_IDLE)
    else $error("precharge did not end in idle");

endmodule // bank_tracker

//--- rtl/cross_bank_command_legality.sv
// Cross-bank command checker for a four-bank double-data-rate memory.
// Assumes command pins already sampled on clk; clock_enable comes from a pin.
`timescale 1ns/1ns

// Notes on behaviour
// - Checks only with clock enable high twice
// - Idle once precharge time has elapsed
// - Row active after activate-to-column time
// - Burst state until completion or termination
// - Auto precharge: access then precharge
// - Read precharge starts at earliest precharge
// - Write precharge starts after write recovery
// - Access runs from command to precharge
// - Other banks accept nondisruptive commands
// - Terminate applies to current burst bank
// - Read and write include both variants
// - Other bank follows its own state
// - Decode activate, read, write, precharge
// - Deselect and nop continue operations
// - Precharging returns idle after precharge time
module cross_bank_command_legality
  import bank_legality_pkg::*;
#(
  parameter int BANKS         = 4,
  parameter int CNT_W         = 5,
  parameter int BURST_LENGTH  = 4,
  parameter int READ_LATENCY  = 2,
  parameter int AP_BIT        = 10
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clock_enable,
  input  wire logic        self_refresh_exit,
  input  wire logic        chip_select_n,
  input  wire logic        row_strobe_n,
  input  wire logic        column_strobe_n,
  input  wire logic        write_enable_n,
  input  wire logic [1:0]  bank_addr,
  input  wire logic [12:0] addr,
  output logic             cmd_accepted,
  output logic             cmd_illegal,
  output logic             timing_violation,
  output logic [BANKS-1:0] bank_idle,
  output logic [BANKS-1:0] bank_busy
);

  localparam int HALF_BL = BURST_LENGTH / 2;
  localparam logic [CNT_W-1:0] HALF_BL_CYC = CNT_W'(HALF_BL);
  localparam logic [CNT_W-1:0] RD_ACCESS = CNT_W'(HALF_BL);
  localparam logic [CNT_W-1:0] WR_ACCESS = CNT_W'(1 + HALF_BL + WRITE_RECOVERY_CYC);
  localparam logic [CNT_W-1:0] WR_TO_RD = CNT_W'(1 + HALF_BL + WRITE_TO_READ_CYC);
  localparam logic [CNT_W-1:0] RD_TO_WR = CNT_W'(READ_LATENCY + HALF_BL);
  localparam logic [CNT_W-1:0] SR_EXIT  = CNT_W'(SELF_REFRESH_EXIT_CYC);

  // ----------------------------------------
  // Pin synchronisers for clock enable
  // ----------------------------------------
  logic [2:0]       cke_sync;
  logic             cke_prev;
  logic [CNT_W-1:0] sr_count;
  logic [CNT_W-1:0] next_sr_count;
  logic             cke_stable;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cke_sync <= 3'h0;
      cke_prev <= 1'b0;
    end
    else
    begin
      cke_sync <= {cke_sync[1:0], clock_enable};
      cke_prev <= cke_stable;
    end
  end

  // Level counts once second and third stages agree
  assign cke_stable = (cke_sync[2] == cke_sync[1]) ? cke_sync[1] : cke_prev;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic [3:0] code;
  cmd_t       cmd;
  logic       checking;
  logic       auto_pre;

  assign code     = {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n};
  assign auto_pre = addr[AP_BIT];
  // only with enable held and exit time met
  assign checking = cke_prev && cke_stable && (sr_count == '0);

  always_comb
  begin
    case (code)
      CODE_ACTIVATE:  cmd = CMD_ACTIVATE;
      CODE_READ:      cmd = CMD_READ;
      CODE_WRITE:     cmd = CMD_WRITE;
      CODE_PRECHARGE: cmd = CMD_PRECHARGE;
      CODE_REFRESH:   cmd = CMD_ALL_BANK;
      CODE_LOAD_MODE: cmd = CMD_ALL_BANK;
      CODE_TERMINATE: cmd = CMD_TERMINATE;
      default:        cmd = CMD_NONE;
    endcase
    if (chip_select_n || !checking)
      cmd = CMD_NONE;
  end

  // Self refresh exit window
  always_comb
  begin
    next_sr_count = (sr_count != '0) ? sr_count - 1'b1 : sr_count;
    if (self_refresh_exit)
      next_sr_count = SR_EXIT;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sr_count <= '0;
    else
      sr_count <= next_sr_count;
  end

  // ----------------------------------------
  // Per-bank trackers
  // ----------------------------------------
  bank_state_t      state [BANKS];
  logic [CNT_W-1:0] count [BANKS];
  logic [BANKS-1:0] hit;
  logic [1:0]       burst_bank;
  logic [1:0]       next_burst_bank;
  logic             legal;
  logic             term_hit;

  for (genvar b = 0; b < BANKS; b++)
  begin : g_bank
    assign hit[b]       = (bank_addr == 2'(b)) && cmd_accepted;
    assign bank_idle[b] = (state[b] == BANK_IDLE);
    assign bank_busy[b] = (state[b] == BANK_READ) || (state[b] == BANK_WRITE)
                          || (state[b] == BANK_AP_ACCESS);
    bank_tracker #(
      .CNT_W (CNT_W)
    ) u_bank (
      .clk        (clk),
      .rst_n      (rst_n),
      .hit        (hit[b]),
      .cmd        (cmd),
      .auto_pre   (auto_pre),
      .access_len (cmd == CMD_WRITE ? WR_ACCESS : RD_ACCESS),
      .burst_len  (HALF_BL_CYC),
      // terminate only the current burst bank
      .terminate  (term_hit && burst_bank == 2'(b)),
      .state      (state[b]),
      .count      (count[b])
    );
  end

  // ----------------------------------------
  // Cross-bank spacing tracker
  // ----------------------------------------
  logic [CNT_W-1:0] rd_block;
  logic [CNT_W-1:0] wr_block;
  logic [CNT_W-1:0] next_rd_block;
  logic [CNT_W-1:0] next_wr_block;
  logic             rd_running;

  assign rd_running = (state[burst_bank] == BANK_READ);
  assign term_hit   = cmd_accepted && cmd == CMD_TERMINATE;

  // Legality of the decoded command against bank states
  always_comb
  begin
    legal = 1'b1;
    case (cmd)
      CMD_ACTIVATE:
        legal = state[bank_addr] == BANK_IDLE;
      CMD_READ, CMD_WRITE:
        legal = state[bank_addr] == BANK_ACTIVE || state[bank_addr] == BANK_READ
                || state[bank_addr] == BANK_WRITE;
      CMD_PRECHARGE:
        legal = state[bank_addr] != BANK_ACTIVATING && state[bank_addr] != BANK_AP_ACCESS;
      CMD_ALL_BANK:
        legal = &bank_idle;
      // terminate must name the read burst bank
      CMD_TERMINATE:
        legal = rd_running && (bank_addr == burst_bank);
      default:
        legal = 1'b1;
    endcase
  end

  // other banks judged by own state
  assign cmd_accepted = (cmd != CMD_NONE) && legal && !timing_violation;
  assign cmd_illegal  = (cmd != CMD_NONE) && !legal;

  always_comb
  begin
    next_rd_block   = (rd_block != '0) ? rd_block - 1'b1 : rd_block;
    next_wr_block   = (wr_block != '0) ? wr_block - 1'b1 : wr_block;
    next_burst_bank = burst_bank;
    if (cmd_accepted && cmd == CMD_WRITE)
    begin
      next_rd_block   = WR_TO_RD;
      next_wr_block   = HALF_BL_CYC;
      next_burst_bank = bank_addr;
    end
    else if (cmd_accepted && cmd == CMD_READ)
    begin
      next_rd_block   = HALF_BL_CYC;
      next_wr_block   = RD_TO_WR;
      next_burst_bank = bank_addr;
    end
    if (term_hit)
      next_wr_block = '0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_block   <= '0;
      wr_block   <= '0;
      burst_bank <= 2'h0;
    end
    else
    begin
      rd_block   <= next_rd_block;
      wr_block   <= next_wr_block;
      burst_bank <= next_burst_bank;
    end
  end

  always_comb
  begin
    timing_violation = 1'b0;
    if (legal && cmd == CMD_READ && rd_block > CNT_W'(CNT_ONE))
      timing_violation = 1'b1;
    if (legal && cmd == CMD_WRITE && wr_block > CNT_W'(CNT_ONE))
      timing_violation = 1'b1;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // all-bank command only when idle
  a_all_bank_idle: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_accepted && cmd == CMD_ALL_BANK |-> bank_idle == '1)
    else $error("all-bank command accepted while busy");

  a_viol_refused: assert property (@(posedge clk) disable iff (!rst_n)
    timing_violation |-> !cmd_accepted)
    else $error("command taken inside spacing window");

  a_cke_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !cke_stable |-> !cmd_accepted)
    else $error("command taken with clock enable low");

  a_wr_rd_gap: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_accepted && cmd == CMD_WRITE |=> rd_block == WR_TO_RD)
    else $error("write to read spacing wrong");

  a_rd_wr_gap: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_accepted && cmd == CMD_READ && !term_hit |=> wr_block == RD_TO_WR)
    else $error("read to write spacing wrong");

  a_act_state: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_accepted && cmd == CMD_ACTIVATE |=> state[$past(bank_addr)] == BANK_ACTIVATING)
    else $error("activate did not open row");

  a_ap_access: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_accepted && cmd == CMD_READ && auto_pre |=> state[$past(bank_addr)] == BANK_AP_ACCESS)
    else $error("auto precharge access not entered");

  a_decode_act: assert property (@(posedge clk) disable iff (!rst_n)
    checking && code == CODE_ACTIVATE |-> cmd == CMD_ACTIVATE)
    else $error("activate decode wrong");

  a_nop_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (chip_select_n || code == CODE_NOP) |-> !cmd_accepted && !cmd_illegal)
    else $error("nop treated as command");

endmodule // cross_bank_command_legality

//--- testbench/ctrl_model.sv
// Controller model driving the command pins of the legality block.
// Assumes requests arrive from the bench one clock ahead of the pins.
`timescale 1ns/1ns
module ctrl_model
  import bank_legality_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [3:0]  code,
  input  wire logic [1:0]  bank,
  input  wire logic        ap,
  output logic             chip_select_n,
  output logic             row_strobe_n,
  output logic             column_strobe_n,
  output logic             write_enable_n,
  output logic [1:0]       bank_addr,
  output logic [12:0]      addr
);
  // ----------------------------------------
  // Pin driver
  // ----------------------------------------
  initial
  begin
    {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = CODE_NOP;
    bank_addr = 2'h0;
    addr      = 13'h0000;
  end

  // only scheduled codes
  // Deselected: chip select held high, other pins show the inverse of their last value
  always @(posedge clk)
  begin
    if (go)
    begin
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= code;
      bank_addr <= bank;
      addr      <= {2'h0, ap, 10'h0a5};
    end
    else
    begin
      chip_select_n <= 1'b1;
      {row_strobe_n, column_strobe_n, write_enable_n} <= ~{row_strobe_n, column_strobe_n, write_enable_n};
      bank_addr <= ~bank_addr;
      addr      <= ~addr;
    end
  end
endmodule // ctrl_model

//--- testbench/cross_bank_command_legality_tb.sv
// Self-checking bench for the cross-bank legality block.
// Assumes the controller model adds one clock between request and pins.
`timescale 1ns/1ns
module cross_bank_command_legality_tb
  import bank_legality_pkg::*;
;
  typedef struct packed {
    logic [3:0] code;
    logic [1:0] bank;
    logic       ap;
    logic [3:0] gap;
    logic [2:0] exp;
  } row_t;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        clock_enable = 1'b1;
  logic        self_refresh_exit = 1'b0;
  logic        go = 1'b0;
  logic [3:0]  code = CODE_NOP;
  logic [1:0]  bank = 2'h0;
  logic        ap = 1'b0;
  logic        cs_l, ras_l, cas_l, we_l;
  logic [1:0]  bank_addr;
  logic [12:0] addr;
  logic        cmd_accepted, cmd_illegal, timing_violation;
  logic [3:0]  bank_idle, bank_busy;
  logic [2:0]  pend_exp;
  logic        pend = 1'b0;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;
  row_t        rows [0:13];

  // ----------------------------------------
  // Clock, timeout and instances
  // ----------------------------------------
  always #10 clk = ~clk;

  // Cycle ceiling for a hung run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  ctrl_model i_ctrl (.clk(clk), .go(go), .code(code), .bank(bank), .ap(ap), .chip_select_n(cs_l),
    .row_strobe_n(ras_l), .column_strobe_n(cas_l), .write_enable_n(we_l), .bank_addr(bank_addr), .addr(addr));

  cross_bank_command_legality i_dut (.clk(clk), .rst_n(rst_n), .clock_enable(clock_enable),
    .self_refresh_exit(self_refresh_exit), .chip_select_n(cs_l), .row_strobe_n(ras_l),
    .column_strobe_n(cas_l), .write_enable_n(we_l), .bank_addr(bank_addr), .addr(addr),
    .cmd_accepted(cmd_accepted), .cmd_illegal(cmd_illegal), .timing_violation(timing_violation),
    .bank_idle(bank_idle), .bank_busy(bank_busy));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic row_t mk(logic [3:0] c, logic [1:0] b, logic a, logic [3:0] g, logic [2:0] e);
    return '{c, b, a, g, e};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One request per clock; flags of the previous request checked mid-cycle
  task automatic step(input logic g, input logic [3:0] c, input logic [1:0] b, input logic a, input logic [2:0] e);
    @(posedge clk);
    go   <= g;
    code <= c;
    bank <= b;
    ap   <= a;
    @(negedge clk);
    if (pend)
      chk({5'h0, cmd_accepted, cmd_illegal, timing_violation}, {5'h0, pend_exp});
    pend     = 1'b1;
    pend_exp = e;
  endtask

  // Idle cycles, deselect only
  task automatic idle(input int n);
    repeat (n) step(1'b0, CODE_NOP, 2'h0, 1'b0, 3'b000);
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rows[0]  = mk(CODE_ACTIVATE, 2'h0, 1'b0, 4'h0, 3'b100);
    rows[1]  = mk(CODE_ACTIVATE, 2'h1, 1'b0, 4'h0, 3'b100);
    rows[2]  = mk(CODE_WRITE, 2'h0, 1'b1, 4'h0, 3'b100);
    rows[3]  = mk(CODE_ACTIVATE, 2'h2, 1'b0, 4'h0, 3'b100);
    rows[4]  = mk(CODE_READ, 2'h1, 1'b0, 4'h0, 3'b001);
    rows[5]  = mk(CODE_READ, 2'h1, 1'b0, 4'h1, 3'b100);
    rows[6]  = mk(CODE_READ, 2'h2, 1'b1, 4'h1, 3'b100);
    rows[7]  = mk(CODE_WRITE, 2'h1, 1'b0, 4'h0, 3'b001);
    rows[8]  = mk(CODE_READ, 2'h1, 1'b0, 4'h0, 3'b100);
    rows[9]  = mk(CODE_READ, 2'h3, 1'b0, 4'h0, 3'b010);
    rows[10] = mk(CODE_WRITE, 2'h1, 1'b0, 4'h2, 3'b100);
    rows[11] = mk(CODE_TERMINATE, 2'h3, 1'b0, 4'h0, 3'b010);
    rows[12] = mk(CODE_REFRESH, 2'h0, 1'b0, 4'h0, 3'b010);
    rows[13] = mk(CODE_PRECHARGE, 2'h1, 1'b0, 4'h4, 3'b100);
    repeat (5) @(negedge clk);
    chk({bank_idle, bank_busy}, 8'hf0);
    chk({5'h0, cmd_accepted, cmd_illegal, timing_violation}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    idle(8);
    foreach (rows[i])
    begin
      idle(rows[i].gap);
      step(1'b1, rows[i].code, rows[i].bank, rows[i].ap, rows[i].exp);
    end
    idle(12);
    chk({4'h0, bank_idle}, 8'h0f);
    step(1'b1, CODE_REFRESH, 2'h0, 1'b0, 3'b100);
    idle(20);
    step(1'b1, CODE_LOAD_MODE, 2'h0, 1'b0, 3'b100);
    idle(20);
    // Commands ignored while clock enable is low
    @(posedge clk);
    clock_enable <= 1'b0;
    idle(6);
    step(1'b1, CODE_ACTIVATE, 2'h0, 1'b0, 3'b000);
    idle(1);
    @(posedge clk);
    clock_enable <= 1'b1;
    idle(8);
    // Self refresh exit wait holds off commands
    @(posedge clk);
    self_refresh_exit <= 1'b1;
    step(1'b1, CODE_ACTIVATE, 2'h3, 1'b0, 3'b000);
    self_refresh_exit <= 1'b0;
    idle(8);
    step(1'b1, CODE_ACTIVATE, 2'h3, 1'b0, 3'b100);
    idle(2);
    wrap_up();
  end
endmodule // cross_bank_command_legality_tb
